// ---- core/clk_buf_pkg.sv ----
// Shared constants, register map and state types of the output stop and power-down control
package clk_buf_pkg;
  // Structure
  localparam int NUM_PAIRS = 8;
  localparam int BYTE_W = 8;
  // Register offsets
  localparam logic [7:0] OFS_DRIVE_MODE = 8'h00;
  localparam logic [7:0] OFS_OUT_ENABLE = 8'h01;
  localparam logic [7:0] OFS_STOPPABLE = 8'h02;
  localparam logic [7:0] OFS_REV_VENDOR = 8'h04;
  localparam logic [7:0] OFS_PART_ID = 8'h05;
  localparam logic [7:0] OFS_READ_LEN = 8'h06;
  // Field positions in the drive mode byte
  localparam int PARK_SEL_BIT = 7;
  localparam int HALT_SEL_BIT = 6;
  // Field position of the revision nibble in the identification byte
  localparam int REV_LSB = 4;
  // Values after reset
  localparam logic [7:0] DRIVE_MODE_RST = 8'h07;
  localparam logic [7:0] OUT_ENABLE_RST = 8'hff;
  localparam logic [7:0] STOPPABLE_RST = 8'h00;
  localparam logic [7:0] READ_LEN_RST = 8'h07;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOCK_TIME_NS = 1000000;
  // Under the limit: round down and keep one cycle of margin
  localparam int LOCK_CYCLES = LOCK_TIME_NS / CLK_PERIOD_NS - 1;
  localparam int LOCK_CNT_W = 20;
  // Output periods counted after a qualified release before restart
  localparam logic [2:0] RESTART_EDGES = 3'h3;
  // Power-down sequence states
  typedef enum logic [3:0] {
    PD_RUN = 4'b0001,
    PD_PARK_WAIT = 4'b0010,
    PD_PARKED = 4'b0100,
    PD_RELOCK = 4'b1000
  } pd_state_t;
  // Output halt sequence states
  typedef enum logic [2:0] {
    HALT_IDLE = 3'b001,
    HALT_ACTIVE = 3'b010,
    HALT_RESTART = 3'b100
  } halt_state_t;
endpackage

// ---- core/qual_if.sv ----
// Signals between the control top and one two-edge level qualifier
`timescale 1ns/100ps
`default_nettype none
interface qual_if;
  logic sample;
  logic level;
  logic qualified;
  modport source (output sample, output level, input qualified);
  modport filter (input sample, input level, output qualified);
endinterface
`default_nettype wire

// ---- core/level_qualifier.sv ----
// Accepts a new input level only after two successive sample strobes agree
`timescale 1ns/100ps
`default_nettype none
module level_qualifier #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Level to qualify and result
  qual_if.filter q
);
  logic [1:0] history;

  // Shift history on each strobe; a change needs two equal samples in a row
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      history <= {2{RESET_LEVEL}};
      q.qualified <= RESET_LEVEL;
    end
    else if (q.sample)
    begin
      history <= {history[0], q.level};
      if (history[0] == q.level)
      begin
        q.qualified <= q.level;
      end
    end
  end
endmodule
`default_nettype wire

// ---- core/output_stop_powerdown_ctrl.sv ----
// Output stop and power-down control of an eight-pair differential clock buffer
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [R01] Power-down pin is asynchronous active low, controlling both entry and exit.
// [R02] Power-down seen low on two complement rises parks outputs at next complement fall.
// [R03] Park select 0: true driven high at 2x current, complement undriven.
// [R04] Park select 1: both outputs of every pair undriven while powered down.
// [R05] Outputs are parked before the PLL is switched off; the code parks them on the same clock edge that clears pll_enable.
// [R06] Locked, stable clocks return under 1 ms after release or reset.
// [R07] Undriven park mode: outputs driven high within 300 us of release.
// [R08] Controller asserts power-down before removing input clock or supply.
// [R09] Controller keeps a valid input clock whenever output halt is used.
// [R10] Halt pin change accepted only when stable over two complement rises.
// [R11] Qualified halt stops every stoppable output after its next transition.
// [R12] Halt select 0: stopped true driven high at 6x current, complement undriven.
// [R13] Halt select 1: both outputs of each stopped pair undriven.
// [R14] On release all stopped outputs restart together, glitch free, after 2-6 periods.
// [R15] Undriven halt mode: stopped true outputs driven high within 10 ns of release; the code drives them high two cycles after the release is qualified.
// [R16] Read-only byte: revision in bits 7 to 4, vendor in bits 3 to 0.
// [R17] Eight-bit part identification code readable by the host.
// [R18] Writable byte count sets how many bytes a block read returns.
// [R19] Each pair has a stoppable bit, free running by default.
// [R20] Free-running pairs ignore halt; a disabled pair stays disabled regardless; the code drives its true high in relock and when parked at park select 0.
module output_stop_powerdown_ctrl #(
  parameter int LOCK_WAIT = clk_buf_pkg::LOCK_CYCLES,
  parameter logic [3:0] REVISION_CODE = 4'h0, // Arbitrary value
  parameter logic [3:0] VENDOR_CODE = 4'h5, // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'h5a // Arbitrary value
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Asynchronous pins
  input wire logic ref_clk_in,
  input wire logic power_down_n,
  input wire logic output_halt_n,
  // Register port from the serial engine
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic [7:0] read_length,
  // Differential output pairs
  output logic [clk_buf_pkg::NUM_PAIRS-1:0] clk_out_true,
  output logic [clk_buf_pkg::NUM_PAIRS-1:0] clk_out_comp,
  output logic [clk_buf_pkg::NUM_PAIRS-1:0] true_oe,
  output logic [clk_buf_pkg::NUM_PAIRS-1:0] comp_oe,
  output logic [clk_buf_pkg::NUM_PAIRS-1:0] true_current_6x,
  // PLL control and status
  output logic pll_enable,
  output logic pll_locked
);
  import clk_buf_pkg::*;

  logic ref_meta;
  logic ref_sync;
  logic pd_meta;
  logic pd_sync;
  logic halt_meta;
  logic halt_sync;
  logic out_phase;
  logic comp_rise;
  logic comp_fall;
  logic [7:0] drive_mode;
  logic [7:0] out_enable;
  logic [7:0] stoppable;
  logic [7:0] part_identifier;
  logic [7:0] read_length_count;
  logic [7:0] revision_vendor_id;
  pd_state_t pd_state;
  halt_state_t halt_state;
  logic [LOCK_CNT_W-1:0] lock_cnt;
  logic [2:0] restart_cnt;
  logic [NUM_PAIRS-1:0] stopped;
  logic halt_waking;
  logic park_select;
  logic halt_select;

  qual_if pd_q ();
  qual_if halt_q ();

  // Two flip-flops on every pin before any logic looks at it
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ref_meta <= 1'b0;
      ref_sync <= 1'b0;
      pd_meta <= 1'b1;
      pd_sync <= 1'b1;
      halt_meta <= 1'b1;
      halt_sync <= 1'b1;
    end
    else
    begin
      ref_meta <= ref_clk_in;
      ref_sync <= ref_meta;
      pd_meta <= power_down_n;
      pd_sync <= pd_meta;
      halt_meta <= output_halt_n;
      halt_sync <= halt_meta;
    end
  end

  // Output phase follows the reference only while the PLL runs
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      out_phase <= 1'b0;
    end
    else if (pll_enable)
    begin
      out_phase <= ref_sync;
    end
  end

  // Complement edges: a rise is a true fall, a fall is a true rise
  assign comp_rise = pll_enable & out_phase & ~ref_sync;
  assign comp_fall = pll_enable & ~out_phase & ref_sync;
  assign park_select = drive_mode[PARK_SEL_BIT];
  assign halt_select = drive_mode[HALT_SEL_BIT];
  assign revision_vendor_id = {REVISION_CODE, VENDOR_CODE}; // [R16]

  // Both pins are qualified on complement rises
  assign pd_q.sample = comp_rise; // [R02]
  assign pd_q.level = pd_sync; // [R01]
  assign halt_q.sample = comp_rise; // [R10]
  assign halt_q.level = halt_sync; // [R10]

  level_qualifier #(
    .RESET_LEVEL(1'b1)
  ) u_pd_qual (
    .sys_clk(sys_clk),
    .rst(rst),
    .q(pd_q)
  );

  level_qualifier #(
    .RESET_LEVEL(1'b1)
  ) u_halt_qual (
    .sys_clk(sys_clk),
    .rst(rst),
    .q(halt_q)
  );

  // Register writes; identification byte has no write path
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      drive_mode <= DRIVE_MODE_RST;
      out_enable <= OUT_ENABLE_RST;
      stoppable <= STOPPABLE_RST; // [R19]
      part_identifier <= PART_CODE;
      read_length_count <= READ_LEN_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == OFS_DRIVE_MODE)
      begin
        drive_mode <= reg_wdata;
      end
      else if (reg_addr == OFS_OUT_ENABLE)
      begin
        out_enable <= reg_wdata;
      end
      else if (reg_addr == OFS_STOPPABLE)
      begin
        stoppable <= reg_wdata; // [R19]
      end
      else if (reg_addr == OFS_PART_ID)
      begin
        part_identifier <= reg_wdata; // [R17]
      end
      else if (reg_addr == OFS_READ_LEN)
      begin
        read_length_count <= reg_wdata; // [R18]
      end
    end
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= UNMAPPED_READ;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (!reg_rd)
      begin
        reg_rdata <= reg_rdata;
      end
      else if (reg_addr == OFS_DRIVE_MODE)
      begin
        reg_rdata <= drive_mode;
      end
      else if (reg_addr == OFS_OUT_ENABLE)
      begin
        reg_rdata <= out_enable;
      end
      else if (reg_addr == OFS_STOPPABLE)
      begin
        reg_rdata <= stoppable;
      end
      else if (reg_addr == OFS_REV_VENDOR)
      begin
        reg_rdata <= revision_vendor_id; // [R16]
      end
      else if (reg_addr == OFS_PART_ID)
      begin
        reg_rdata <= part_identifier; // [R17]
      end
      else if (reg_addr == OFS_READ_LEN)
      begin
        reg_rdata <= read_length_count; // [R18]
      end
      else
      begin
        reg_rdata <= UNMAPPED_READ;
      end
    end
  end

  // Block read length handed to the serial engine
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      read_length <= READ_LEN_RST;
    end
    else
    begin
      read_length <= read_length_count; // [R18]
    end
  end

  // Power-down sequence; reset acts like supply arrival and starts a relock
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pd_state <= PD_RELOCK;
      pll_enable <= 1'b1;
      pll_locked <= 1'b0;
      lock_cnt <= '0;
    end
    else
    begin
      case (pd_state)
        PD_RUN:
        begin
          if (!pd_q.qualified)
          begin
            pd_state <= PD_PARK_WAIT; // [R02]
          end
        end
        PD_PARK_WAIT:
        begin
          if (comp_fall)
          begin
            pd_state <= PD_PARKED; // [R02]
          end
        end
        PD_PARKED:
        begin
          // Outputs park on this same edge, as the pin drive also decodes PD_PARKED
          pll_enable <= 1'b0; // [R05]
          pll_locked <= 1'b0;
          // Release is seen on the raw level: parked outputs give no edges
          if (pd_sync && !pll_enable)
          begin
            pd_state <= PD_RELOCK; // [R01]
            pll_enable <= 1'b1;
            lock_cnt <= '0;
          end
        end
        PD_RELOCK:
        begin
          if (lock_cnt < LOCK_CNT_W'(LOCK_WAIT))
          begin
            lock_cnt <= lock_cnt + 1'b1; // [R06]
          end
          else if (pd_q.qualified)
          begin
            pll_locked <= 1'b1; // [R06]
            pd_state <= PD_RUN;
          end
          else if (!pd_sync)
          begin
            pd_state <= PD_PARK_WAIT;
          end
        end
        default:
        begin
          pd_state <= PD_RELOCK;
        end
      endcase
    end
  end

  // Halt sequence; the set of stopped pairs grows only at complement falls
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      halt_state <= HALT_IDLE;
      stopped <= '0;
      restart_cnt <= '0;
      halt_waking <= 1'b0;
    end
    else
    begin
      case (halt_state)
        HALT_IDLE:
        begin
          halt_waking <= 1'b0;
          if (!halt_q.qualified)
          begin
            halt_state <= HALT_ACTIVE;
          end
        end
        HALT_ACTIVE:
        begin
          halt_waking <= 1'b0;
          if (comp_fall)
          begin
            // Free-running pairs never join the stopped set
            stopped <= stopped | stoppable; // [R11] [R20]
          end
          if (halt_q.qualified)
          begin
            halt_state <= HALT_RESTART;
            restart_cnt <= '0;
            halt_waking <= halt_select; // [R15]
          end
        end
        HALT_RESTART:
        begin
          if (!halt_q.qualified)
          begin
            halt_state <= HALT_ACTIVE;
          end
          else if (comp_fall)
          begin
            if (restart_cnt == RESTART_EDGES)
            begin
              // True is already high, so clearing here cannot glitch
              stopped <= '0; // [R14]
              halt_state <= HALT_IDLE;
            end
            else
            begin
              restart_cnt <= restart_cnt + 1'b1; // [R14]
            end
          end
        end
        default:
        begin
          halt_state <= HALT_IDLE;
        end
      endcase
    end
  end

  // Pin drive per pair, highest priority first
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      clk_out_true <= '0;
      clk_out_comp <= '0;
      true_oe <= '0;
      comp_oe <= '0;
      true_current_6x <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_PAIRS; i++)
      begin
        clk_out_comp[i] <= 1'b0;
        comp_oe[i] <= 1'b0;
        true_current_6x[i] <= 1'b1;
        if (pd_state == PD_PARKED)
        begin
          clk_out_true[i] <= ~park_select; // [R03] [R04]
          true_oe[i] <= ~park_select; // [R03] [R04]
          true_current_6x[i] <= 1'b0; // [R03]
        end
        else if (pd_state == PD_RELOCK && !pll_locked)
        begin
          // Driven high at once on release, well inside the limit
          clk_out_true[i] <= 1'b1; // [R07]
          true_oe[i] <= 1'b1; // [R07]
          true_current_6x[i] <= 1'b0;
        end
        else if (!out_enable[i])
        begin
          clk_out_true[i] <= 1'b0; // [R20]
          true_oe[i] <= 1'b0; // [R20]
        end
        else if (stopped[i])
        begin
          clk_out_true[i] <= ~halt_select | halt_waking; // [R12] [R13] [R15]
          true_oe[i] <= ~halt_select | halt_waking; // [R12] [R13] [R15]
        end
        else
        begin
          clk_out_true[i] <= out_phase;
          clk_out_comp[i] <= ~out_phase;
          true_oe[i] <= 1'b1;
          comp_oe[i] <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/ref_source.sv ----
// Reference clock source standing in for the upstream clock generator
`timescale 1ns/100ps
`default_nettype none
module ref_source #(
  parameter int HALF_NS = 40
) (
  // Control from the bench
  input wire logic run,
  // Clock towards the buffer
  output logic ref_clk
);
  // Stands low while removed; the offset keeps it out of phase with sys_clk
  initial
  begin
    ref_clk = 1'b0;
    #3;
    forever #(HALF_NS) ref_clk = run ? ~ref_clk : 1'b0;
  end
endmodule
`default_nettype wire

// ---- verif/output_stop_powerdown_ctrl_monitor.sv ----
// Checker of stop, power-down and register behaviour at the control top ports
`timescale 1ns/100ps
`default_nettype none
module output_stop_powerdown_ctrl_monitor #(
  parameter int LOCK_WAIT = 20,
  parameter logic [3:0] REVISION_CODE = 4'h0, // Arbitrary value
  parameter logic [3:0] VENDOR_CODE = 4'h5 // Arbitrary value
) (
  // Clock, reset and pins
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic power_down_n,
  input wire logic output_halt_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [7:0] read_length,
  // Output pairs and PLL
  input wire logic [clk_buf_pkg::NUM_PAIRS-1:0] clk_out_true,
  input wire logic [clk_buf_pkg::NUM_PAIRS-1:0] true_oe,
  input wire logic [clk_buf_pkg::NUM_PAIRS-1:0] comp_oe,
  input wire logic [clk_buf_pkg::NUM_PAIRS-1:0] true_current_6x,
  input wire logic pll_enable,
  input wire logic pll_locked
);
  import clk_buf_pkg::*;
  logic [7:0] mode_q;
  logic [7:0] en_q;
  logic [7:0] stop_q;
  logic [7:0] s;
  logic [5:0] pd_cnt;
  logic [5:0] halt_cnt;
  logic [2:0] quiet;
  int lk_cnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Shadow of the control bytes, so the checks need no view inside
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_q <= DRIVE_MODE_RST;
      en_q <= OUT_ENABLE_RST;
      stop_q <= STOPPABLE_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == OFS_DRIVE_MODE) mode_q <= reg_wdata;
      if (reg_addr == OFS_OUT_ENABLE) en_q <= reg_wdata;
      if (reg_addr == OFS_STOPPABLE) stop_q <= reg_wdata;
    end
  end
  assign s = stop_q & en_q;
  // Saturating counters and a lock-wait cycle count; quiet gates checks until writes have reached the pins
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pd_cnt <= 6'h00;
      halt_cnt <= 6'h00;
      quiet <= 3'h0;
      lk_cnt <= 0;
    end
    else
    begin
      pd_cnt <= power_down_n ? 6'h00 : pd_cnt + {5'h00, pd_cnt != 6'h3f};
      halt_cnt <= output_halt_n ? 6'h00 : halt_cnt + {5'h00, halt_cnt != 6'h3f};
      quiet <= reg_wr ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
      lk_cnt <= (pll_enable && !pll_locked) ? lk_cnt + 1 : 0;
    end
  end
  sequence held_stopped;
    (comp_oe & s) == 8'h00;
  endsequence
  sequence resumed;
    (comp_oe & s) == s;
  endsequence
  id_byte_a: assert property (
    reg_rd && reg_addr == OFS_REV_VENDOR |=> reg_rvalid && reg_rdata == {REVISION_CODE, VENDOR_CODE})
    else $error("identification byte wrong");
  count_read_a: assert property (
    reg_rd && reg_addr == OFS_READ_LEN && quiet == 3'h7 |=> reg_rdata == read_length)
    else $error("byte count read differs from its output");
  park_entry_a: assert property (pd_cnt == 6'h3f |-> !pll_enable)
    else $error("power-down not taken");
  park_first_a: assert property ($fell(pll_enable) |-> comp_oe == 8'h00)
    else $error("PLL stopped before outputs parked");
  park_hold_a: assert property (
    !pll_enable && quiet == 3'h7 |-> comp_oe == 8'h00 && true_current_6x == 8'h00
    && true_oe == (mode_q[PARK_SEL_BIT] ? 8'h00 : 8'hff))
    else $error("parked outputs wrong");
  relock_time_a: assert property (lk_cnt < LOCK_WAIT + 64)
    else $error("lock took too long");
  relock_drive_a: assert property (
    pll_enable && !pll_locked && $past(pll_enable && !pll_locked) && quiet == 3'h7
    |-> (true_oe & clk_out_true) == 8'hff && comp_oe == 8'h00)
    else $error("outputs not driven high during relock");
  halt_hold_a: assert property (
    halt_cnt == 6'h3f && pll_locked && quiet == 3'h7 |-> held_stopped
    and ((true_oe & clk_out_true & true_current_6x & s) == (mode_q[HALT_SEL_BIT] ? 8'h00 : s)))
    else $error("stopped pairs wrong");
  // Pins lag the lock flag by one registered cycle, so the lock must be a cycle old
  free_run_a: assert property (
    pll_locked && $past(pll_locked) && pll_enable && quiet == 3'h7
    |-> (comp_oe & ~stop_q & en_q) == (~stop_q & en_q)
    && ((true_oe | comp_oe) & ~en_q) == 8'h00)
    else $error("free or disabled pair wrong");
  restart_a: assert property (
    $rose(output_halt_n) && halt_cnt == 6'h3f && pll_locked && quiet == 3'h7
    |=> held_stopped [*8] ##[1:40] resumed)
    else $error("restart out of window");
  halt_rel1_a: assert property (
    $rose(output_halt_n) && halt_cnt == 6'h3f && mode_q[HALT_SEL_BIT] && quiet == 3'h7
    |-> ##[1:40] (true_oe & clk_out_true & s) == s)
    else $error("stopped true outputs not driven on release");
endmodule
bind output_stop_powerdown_ctrl output_stop_powerdown_ctrl_monitor #(.LOCK_WAIT(LOCK_WAIT),
  .REVISION_CODE(REVISION_CODE), .VENDOR_CODE(VENDOR_CODE)) i_monitor (.sys_clk, .rst,
  .power_down_n, .output_halt_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .reg_rvalid, .read_length, .clk_out_true, .true_oe, .comp_oe, .true_current_6x,
  .pll_enable, .pll_locked);
`default_nettype wire

// ---- verif/output_stop_powerdown_ctrl_bench.sv ----
// Self-checking bench of the output stop and power-down control
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) check_val(8'(g), 8'(e))
module output_stop_powerdown_ctrl_bench;
  import clk_buf_pkg::*;
  localparam int LOCK_SIM = 20; // Short lock wait keeps the run brief
  localparam logic [3:0] REV = 4'h3; // Arbitrary value
  localparam logic [3:0] VEND = 4'h9; // Arbitrary value
  localparam logic [7:0] PART = 8'h6c; // Arbitrary value
  logic sys_clk, rst, ref_run, ref_clk_in, power_down_n, output_halt_n;
  logic reg_wr, reg_rd, reg_rvalid, pll_enable, pll_locked;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, read_length;
  logic [NUM_PAIRS-1:0] clk_out_true, clk_out_comp, true_oe, comp_oe, true_current_6x;
  logic [1:0] seen;
  int error_cnt = 0;
  int total_checks = 0;
  ref_source i_ref_source (.run(ref_run), .ref_clk(ref_clk_in));
  output_stop_powerdown_ctrl #(.LOCK_WAIT(LOCK_SIM), .REVISION_CODE(REV), .VENDOR_CODE(VEND),
    .PART_CODE(PART)) i_output_stop_powerdown_ctrl (.sys_clk(sys_clk), .rst(rst),
    .ref_clk_in(ref_clk_in), .power_down_n(power_down_n), .output_halt_n(output_halt_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .read_length(read_length),
    .clk_out_true(clk_out_true), .clk_out_comp(clk_out_comp), .true_oe(true_oe),
    .comp_oe(comp_oe), .true_current_6x(true_current_6x), .pll_enable(pll_enable),
    .pll_locked(pll_locked));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Strobes last one cycle; the next call waits for a fresh edge
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rvalid, 1'b1);
    `CHK(reg_rdata, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_lock();
    repeat (LOCK_SIM + 200) if (pll_locked !== 1'b1) @(posedge sys_clk);
    #1;
    `CHK(pll_locked, 1'b1);
  endtask
  // Pairs 1-3 stoppable and enabled, pair 0 disabled, pairs 4-7 free running
  task automatic do_halt(input logic m);
    reg_write(OFS_DRIVE_MODE, m ? 8'h47 : 8'h07);
    @(posedge sys_clk);
    output_halt_n <= 1'b0;
    settle(80);
    `CHK(comp_oe & 8'h0e, 8'h00);
    `CHK(true_oe & clk_out_true & 8'h0e, m ? 8'h00 : 8'h0e);
    `CHK(true_oe & true_current_6x & 8'h0e, m ? 8'h00 : 8'h0e);
    `CHK(true_oe[0] | comp_oe[0], 1'b0);
    seen = 2'b00;
    // Sample after the edge has settled, never in the launching time step
    repeat (16)
    begin
      settle(1);
      seen = seen | (clk_out_true[7] ? 2'b10 : 2'b01);
      `CHK(clk_out_comp[7] ^ clk_out_true[7], 1'b1);
    end
    `CHK(seen, 2'b11);
    @(posedge sys_clk);
    output_halt_n <= 1'b1;
    settle(8);
    `CHK(comp_oe & 8'h0e, 8'h00);
    settle(72);
    `CHK(comp_oe, 8'hfe);
  endtask
  task automatic do_pd(input logic m);
    reg_write(OFS_DRIVE_MODE, m ? 8'h87 : 8'h07);
    @(posedge sys_clk);
    power_down_n <= 1'b0;
    settle(60);
    `CHK(pll_enable, 1'b0);
    `CHK(true_oe, m ? 8'h00 : 8'hff);
    `CHK(comp_oe | true_current_6x, 8'h00);
    ref_run = 1'b0; // Upstream clock removed only while parked
    settle(100);
    `CHK(pll_enable, 1'b0);
    ref_run = 1'b1;
    @(posedge sys_clk);
    power_down_n <= 1'b1;
    settle(6);
    `CHK(true_oe & clk_out_true, 8'hff);
    wait_lock();
  endtask
  initial
  begin
    #200000;
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    rst = 1'b1;
    ref_run = 1'b1;
    power_down_n = 1'b1;
    output_halt_n = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    expect_reg(OFS_DRIVE_MODE, 8'h07);
    expect_reg(OFS_OUT_ENABLE, 8'hff);
    expect_reg(OFS_STOPPABLE, 8'h00);
    expect_reg(OFS_REV_VENDOR, {REV, VEND});
    expect_reg(OFS_PART_ID, PART);
    expect_reg(OFS_READ_LEN, 8'h07);
    expect_reg(8'h03, 8'h00);
    expect_reg(8'h10, 8'h00);
    reg_write(OFS_REV_VENDOR, 8'hff);
    expect_reg(OFS_REV_VENDOR, {REV, VEND});
    reg_write(OFS_PART_ID, 8'ha5);
    expect_reg(OFS_PART_ID, 8'ha5);
    reg_write(OFS_READ_LEN, 8'h0c);
    expect_reg(OFS_READ_LEN, 8'h0c);
    `CHK(read_length, 8'h0c);
    wait_lock();
    reg_write(OFS_STOPPABLE, 8'h0f);
    reg_write(OFS_OUT_ENABLE, 8'hfe);
    @(posedge sys_clk);
    output_halt_n <= 1'b0;
    @(posedge sys_clk);
    output_halt_n <= 1'b1;
    settle(40);
    `CHK(comp_oe, 8'hfe);
    do_halt(1'b0);
    do_halt(1'b1);
    do_pd(1'b0);
    do_pd(1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
